// ==== rtl/adc_ctrl_map.svh ====
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define CONV_CYCLES_NORMAL 5'd13
`define CONV_CYCLES_FIRST 5'd25
`define SAMPLE_CYCLE_NORMAL 5'd1
`define SAMPLE_CYCLE_FIRST 5'd13
`define SAMPLE_CYCLE_AUTO 5'd2
`define PRESC_RESET_VALUE 7'h00
`define RESULT_RESET_VALUE 16'h0000
`define SELECT_RESET_VALUE 6'h00
`define TRIG_SRC_SELF 3'h0
`endif

// ==== rtl/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
    typedef struct packed {
        logic [1:0] reference_select_field;
        logic [3:0] channel_select_field;
    } select_t;
    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } result_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_DONE
    } conv_state_t;
endpackage : adc_ctrl_pkg

// ==== rtl/sar_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the analog SAR core: holds the sampled input and returns it
// as the code on completion.
module sar_core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sample_in,
    input wire logic [9:0] analog_in,
    input wire logic finish_in,
    output logic [9:0] code_out,
    output logic code_valid_out
);
    logic [9:0] held_r;
    logic [9:0] held_nxt;
    logic [9:0] code_r;
    logic [9:0] code_nxt;
    logic valid_r;
    logic valid_nxt;

    always_comb begin
        held_nxt = sample_in ? analog_in : held_r;
        code_nxt = finish_in ? held_r : code_r;
        valid_nxt = finish_in;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            held_r <= 10'h000;
            code_r <= 10'h000;
            valid_r <= 1'b0;
        end else begin
            held_r <= held_nxt;
            code_r <= code_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign code_out = code_r;
    assign code_valid_out = valid_r;
endmodule : sar_core_model
`default_nettype wire

// ==== rtl/sar_adc_conversion_control.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_map.svh"
module sar_adc_conversion_control (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic converter_enable_bit_in,
    input wire logic start_conversion_write_in,
    input wire logic auto_trigger_enable_bit_in,
    input wire logic [2:0] trigger_select_field_in,
    input wire logic [7:0] trigger_sources_in,
    input wire logic [2:0] prescaler_select_field_in,
    input wire logic result_alignment_bit_in,
    input wire adc_ctrl_pkg::select_t select_in,
    input wire logic flag_clear_in,
    input wire logic low_byte_read_in,
    input wire logic high_byte_read_in,
    input wire logic [9:0] analog_in,
    output logic start_conversion_bit_out,
    output logic conversion_complete_flag_out,
    output adc_ctrl_pkg::result_t result_out,
    output adc_ctrl_pkg::select_t active_select_out,
    output logic analog_power_out
);
    import adc_ctrl_pkg::*;

    // Trigger sources come from other logic on this clock, so no sync
    logic [6:0] presc_r;
    logic [6:0] presc_nxt;
    logic tick;
    logic [7:0] trig_src;
    logic trig_prev_r;
    logic trig_prev_nxt;
    logic trig_edge;
    conv_state_t state_r;
    conv_state_t state_nxt;
    logic [4:0] cyc_r;
    logic [4:0] cyc_nxt;
    logic first_r;
    logic first_nxt;
    logic auto_r;
    logic auto_nxt;
    logic pend_r;
    logic pend_nxt;
    logic busy_r;
    logic busy_nxt;
    logic flag_r;
    logic flag_nxt;
    logic lock_r;
    logic lock_nxt;
    result_t res_r;
    result_t res_nxt;
    select_t sel_r;
    select_t sel_nxt;
    logic power_r;
    logic power_nxt;
    logic sample_p;
    logic finish_p;
    logic [9:0] code;
    logic code_valid;
    logic self_trig;
    logic auto_on;
    logic [4:0] sample_at;
    logic [4:0] len;

    function automatic logic presc_tick(input logic [6:0] cnt,
                                        input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'h00;
        case (sel)
            3'h0, 3'h1: mask = 7'h01;
            3'h2: mask = 7'h03;
            3'h3: mask = 7'h07;
            3'h4: mask = 7'h0f;
            3'h5: mask = 7'h1f;
            3'h6: mask = 7'h3f;
            default: mask = 7'h7f;
        endcase
        presc_tick = ((cnt & mask) == mask);
    endfunction : presc_tick

    assign auto_on = auto_trigger_enable_bit_in;
    assign self_trig = trigger_select_field_in == `TRIG_SRC_SELF;
    // Source 0 is the converter's own completion flag
    assign trig_src = {trigger_sources_in[7:1], flag_r};
    assign trig_edge = auto_on && trig_src[trigger_select_field_in]
        && !trig_prev_r;
    assign tick = converter_enable_bit_in
        && presc_tick(presc_r, prescaler_select_field_in);

    always_comb begin
        presc_nxt = presc_r + 7'd1;
        if (!converter_enable_bit_in) begin
            presc_nxt = `PRESC_RESET_VALUE;
        end else if (trig_edge && state_r == ST_IDLE) begin
            presc_nxt = `PRESC_RESET_VALUE;
        end
    end

    always_comb begin
        if (first_r) begin
            sample_at = `SAMPLE_CYCLE_FIRST;
            len = `CONV_CYCLES_FIRST;
        end else if (auto_r) begin
            sample_at = `SAMPLE_CYCLE_AUTO;
            len = `CONV_CYCLES_NORMAL;
        end else begin
            sample_at = `SAMPLE_CYCLE_NORMAL;
            len = `CONV_CYCLES_NORMAL;
        end
        sample_p = tick && state_r == ST_CONVERT && cyc_r == sample_at;
        finish_p = tick && state_r == ST_CONVERT && cyc_r == len - 5'd1;
    end

    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        first_nxt = first_r;
        auto_nxt = auto_r;
        pend_nxt = pend_r;
        busy_nxt = busy_r;
        trig_prev_nxt = trig_src[trigger_select_field_in];
        power_nxt = converter_enable_bit_in;
        if (start_conversion_write_in && converter_enable_bit_in) begin
            pend_nxt = 1'b1;
            busy_nxt = 1'b1;
        end
        if (!converter_enable_bit_in) begin
            state_nxt = ST_IDLE;
            first_nxt = 1'b1;
            pend_nxt = 1'b0;
            busy_nxt = 1'b0;
            cyc_nxt = 5'd0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // Edges seen only here, so busy periods ignore them
                    if (trig_edge && !(self_trig && !busy_r)) begin
                        state_nxt = ST_CONVERT;
                        auto_nxt = !first_r;
                        busy_nxt = 1'b1;
                        cyc_nxt = 5'd0;
                    end else if ((pend_r || start_conversion_write_in)
                            && tick) begin
                        state_nxt = ST_CONVERT;
                        auto_nxt = 1'b0;
                        pend_nxt = 1'b0;
                        cyc_nxt = 5'd0;
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        cyc_nxt = cyc_r + 5'd1;
                    end
                    if (finish_p) begin
                        state_nxt = ST_DONE;
                        first_nxt = 1'b0;
                    end
                end
                default: begin
                    cyc_nxt = 5'd0;
                    auto_nxt = 1'b0;
                    if (auto_on && self_trig) begin
                        state_nxt = ST_CONVERT;
                    end else begin
                        state_nxt = ST_IDLE;
                        busy_nxt = pend_nxt;
                    end
                end
            endcase
        end
    end

    always_comb begin
        flag_nxt = flag_r;
        if (flag_clear_in) begin
            flag_nxt = 1'b0;
        end
        if (code_valid) begin
            flag_nxt = 1'b1;
        end
        lock_nxt = lock_r;
        if (low_byte_read_in) begin
            lock_nxt = 1'b1;
        end
        if (high_byte_read_in) begin
            lock_nxt = 1'b0;
        end
        res_nxt = res_r;
        if (code_valid && !lock_r) begin
            if (result_alignment_bit_in) begin
                res_nxt = {code, 6'h00};
            end else begin
                res_nxt = {6'h00, code};
            end
        end
        sel_nxt = sel_r;
        // Tracks while enabled and idle with no start pending or trigger edge, and during the last cycle
        if (converter_enable_bit_in
                && (state_r == ST_IDLE && !pend_r && !trig_edge
                    || finish_p)) begin
            sel_nxt = select_in;
        end
    end

    sar_core_model u_core (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sample_in(sample_p),
        .analog_in(analog_in),
        .finish_in(finish_p),
        .code_out(code),
        .code_valid_out(code_valid)
    );

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc_r <= `PRESC_RESET_VALUE;
            trig_prev_r <= 1'b0;
            state_r <= ST_IDLE;
            cyc_r <= 5'd0;
            first_r <= 1'b1;
            auto_r <= 1'b0;
            pend_r <= 1'b0;
            busy_r <= 1'b0;
            flag_r <= 1'b0;
            lock_r <= 1'b0;
            res_r <= `RESULT_RESET_VALUE;
            sel_r <= `SELECT_RESET_VALUE;
            power_r <= 1'b0;
        end else begin
            presc_r <= presc_nxt;
            trig_prev_r <= trig_prev_nxt;
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            first_r <= first_nxt;
            auto_r <= auto_nxt;
            pend_r <= pend_nxt;
            busy_r <= busy_nxt;
            flag_r <= flag_nxt;
            lock_r <= lock_nxt;
            res_r <= res_nxt;
            sel_r <= sel_nxt;
            power_r <= power_nxt;
        end
    end

    assign start_conversion_bit_out = busy_r;
    assign conversion_complete_flag_out = flag_r;
    assign result_out = res_r;
    assign active_select_out = sel_r;
    assign analog_power_out = power_r;
    prescaler_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !converter_enable_bit_in |=> presc_r == 7'h00)
        else $error("prescaler not held in reset while disabled");
    flag_on_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
        finish_p |=> ##1 flag_r)
        else $error("completion flag not raised");
    lock_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        lock_r && !high_byte_read_in |=> $stable(res_r))
        else $error("result changed while locked");
    busy_in_conv_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_r == ST_CONVERT |-> busy_r)
        else $error("start bit low during conversion");
    sel_frozen_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_r == ST_CONVERT && !finish_p |=> $stable(sel_r))
        else $error("selection changed mid conversion");
    single_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_r == ST_DONE && !(auto_on && self_trig) && !pend_r
        && !start_conversion_write_in && converter_enable_bit_in
        |=> !busy_r)
        else $error("start bit not cleared after single conversion");
    free_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_r == ST_DONE && auto_on && self_trig && converter_enable_bit_in
        |=> state_r == ST_CONVERT && busy_r)
        else $error("free running did not restart");
    trig_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_r == ST_IDLE && trig_edge && converter_enable_bit_in
        |=> presc_r == 7'h00)
        else $error("trigger did not reset prescaler");
    align_a: assert property (@(posedge clk_in) disable iff (rst_in)
        code_valid && !lock_r && !result_alignment_bit_in
        |=> res_r[15:10] == 6'h00)
        else $error("right alignment wrong");
endmodule : sar_adc_conversion_control
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import adc_ctrl_pkg::*;
    logic clk_in, rst_in, en, wr, ate, align, fclr, lrd, hrd;
    logic [2:0] tsel;
    logic [2:0] psel;
    logic [7:0] tsrc;
    logic [9:0] ain;
    select_t sel;
    select_t asel;
    result_t res;
    logic sbit, flag, pwr;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    sar_adc_conversion_control sar_adc_conversion_control_inst (
        .clk_in(clk_in), .rst_in(rst_in), .converter_enable_bit_in(en),
        .start_conversion_write_in(wr), .auto_trigger_enable_bit_in(ate),
        .trigger_select_field_in(tsel), .trigger_sources_in(tsrc),
        .prescaler_select_field_in(psel), .result_alignment_bit_in(align),
        .select_in(sel), .flag_clear_in(fclr), .low_byte_read_in(lrd),
        .high_byte_read_in(hrd), .analog_in(ain),
        .start_conversion_bit_out(sbit), .conversion_complete_flag_out(flag),
        .result_out(res), .active_select_out(asel), .analog_power_out(pwr)
    );

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // A hang counts against the run instead of stalling it
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_in);
            #5;
        end
    endtask : tick

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask : check

    task automatic pulse_start;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
    endtask : pulse_start

    task automatic clear_flag;
        fclr = 1'b1;
        tick(1);
        fclr = 1'b0;
    endtask : clear_flag

    task automatic wait_done(output int n);
        n = 0;
        while (flag !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        check("completion flag", {15'h0, flag}, 16'h1);
    endtask : wait_done

    // cyc is the expected system clocks from start write to flag
    task automatic convert(input logic [9:0] v, input int cyc);
        int n;
        ain = v;
        clear_flag();
        pulse_start();
        check("start bit busy", {15'h0, sbit}, 16'h1);
        wait_done(n);
        check("length", 16'(n >= cyc - 2 && n <= cyc + 8), 16'h1);
        check("start bit done", {15'h0, sbit}, 16'h0);
    endtask : convert

    task automatic t_reset;
        check("start bit", {15'h0, sbit}, 16'h0);
        check("flag", {15'h0, flag}, 16'h0);
        check("result", res, 16'h0000);
        check("power off", {15'h0, pwr}, 16'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_single;
        int n;
        // Power-reduction bit is taken as already cleared here
        en = 1'b1;
        tick(2);
        check("power on", {15'h0, pwr}, 16'h1);
        convert(10'h2a5, 50);
        check("right aligned", res, 16'h02a5);
        convert(10'h3ff, 26);
        check("right aligned", res, 16'h03ff);
        psel = 3'h2;
        convert(10'h0c3, 52);
        check("divide by four", res, 16'h00c3);
        // Divide by 128 puts the converter clock in the full-resolution band
        psel = 3'h7;
        ain = 10'h2d2;
        clear_flag();
        pulse_start();
        wait_done(n);
        check("slowest clock", 16'(n >= 1664 && n <= 1800), 16'h1);
        check("slow result", res, 16'h02d2);
        psel = 3'h0;
        align = 1'b1;
        convert(10'h1c7, 26);
        check("left aligned", res, {10'h1c7, 6'h00});
        align = 1'b0;
        $display("single conversion test done");
    endtask : t_single

    task automatic t_lock;
        convert(10'h155, 26);
        lrd = 1'b1;
        tick(1);
        lrd = 1'b0;
        convert(10'h0aa, 26);
        check("locked result", res, 16'h0155);
        hrd = 1'b1;
        tick(1);
        hrd = 1'b0;
        convert(10'h0aa, 26);
        check("unlocked result", res, 16'h00aa);
        $display("lock test done");
    endtask : t_lock

    task automatic t_select;
        int n;
        sel = 6'h25;
        tick(2);
        check("tracks idle", {10'h0, asel}, 16'h0025);
        clear_flag();
        pulse_start();
        tick(4);
        sel = 6'h1a;
        tick(2);
        check("frozen", {10'h0, asel}, 16'h0025);
        wait_done(n);
        tick(2);
        check("applied after", {10'h0, asel}, 16'h001a);
        $display("selection test done");
    endtask : t_select

    task automatic t_auto;
        int n;
        tsel = 3'h3;
        clear_flag();
        tsrc[3] = 1'b1;
        tick(30);
        check("no trigger while disabled", {15'h0, flag}, 16'h0);
        tsrc[3] = 1'b0;
        ate = 1'b1;
        tick(1);
        tsrc[5] = 1'b1;
        tick(30);
        check("other source ignored", {15'h0, flag}, 16'h0);
        tsrc[3] = 1'b1;
        tick(4);
        check("triggered busy", {15'h0, sbit}, 16'h1);
        tsrc[3] = 1'b0;
        tick(4);
        tsrc[3] = 1'b1;
        wait_done(n);
        check("trigger length", 16'(n <= 36), 16'h1);
        clear_flag();
        tick(40);
        check("held trigger", {15'h0, flag}, 16'h0);
        check("held idle", {15'h0, sbit}, 16'h0);
        tsrc[3] = 1'b0;
        convert(10'h0f0, 26);
        tsrc = 8'h00;
        $display("auto trigger test done");
    endtask : t_auto

    task automatic t_free;
        int n;
        tsel = 3'h0;
        clear_flag();
        tick(40);
        check("needs first write", {15'h0, sbit}, 16'h0);
        ain = 10'h111;
        pulse_start();
        wait_done(n);
        check("stays busy", {15'h0, sbit}, 16'h1);
        ain = 10'h222;
        tick(60);
        check("keeps converting", res, 16'h0222);
        ate = 1'b0;
        n = 0;
        while (sbit !== 1'b0 && n < 60) begin
            tick(1);
            n++;
        end
        check("stops", {15'h0, sbit}, 16'h0);
        $display("free running test done");
    endtask : t_free

    task automatic t_disable;
        en = 1'b0;
        clear_flag();
        tick(2);
        check("power off", {15'h0, pwr}, 16'h0);
        pulse_start();
        tick(60);
        check("no conversion", {15'h0, flag}, 16'h0);
        en = 1'b1;
        tick(3);
        convert(10'h3c3, 50);
        check("result", res, 16'h03c3);
        $display("disable test done");
    endtask : t_disable

    initial begin
        rst_in = 1'b1;
        {en, wr, ate, align, fclr, lrd, hrd} = 7'h00;
        tsel = 3'h0;
        psel = 3'h0;
        tsrc = 8'h00;
        ain = 10'h000;
        sel = 6'h00;
        repeat (12) @(posedge clk_in);
        #5;
        rst_in = 1'b0;
        tick(1);
        t_reset();
        t_single();
        t_lock();
        t_select();
        t_auto();
        t_free();
        t_disable();
        close_out();
    end
endmodule : testbench
`default_nettype wire
